// ---- scss_map.svh ----
// constants for the speed command source selector
`ifndef SCSS_MAP_SVH
`define SCSS_MAP_SVH
`define SCSS_CMD_W 18
`define SCSS_ADC_W 16
`define SCSS_SCALE_W 16
`define SCSS_PRESET_MAX 18'sh0c350
`define SCSS_PRESET_MIN (-18'sh0c350)
`define SCSS_SCALE_SHIFT 15
`define SCSS_CMD_RESET 18'h00000
`endif

// ---- scss_pkg.sv ----
// types for the speed command source selector
package scss_pkg;
   // speed select code from the two select inputs
   typedef enum logic [1:0] {
      SCSS_SEL_BASE,
      SCSS_SEL_PRESET1,
      SCSS_SEL_PRESET2,
      SCSS_SEL_PRESET3
   } scss_sel_e;
   // control mode family
   typedef enum logic [1:0] {
      SCSS_MODE_SPEED,
      SCSS_MODE_SPEED_ZERO,
      SCSS_MODE_TORQUE,
      SCSS_MODE_TORQUE_ZERO
   } scss_mode_e;
   typedef logic signed [17:0] scss_cmd_t;
endpackage

// ---- scss_selector.sv ----
// speed command source selector: picks analog, zero or preset speed command
// *****************************************************************
// *****************************************************************
`timescale 1ns/10ps
`include "scss_map.svh"

module scss_selector (
   // clock, reset, enable
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_ce,
   // select pins from the external controller
   input wire logic i_speed_select_bit0,
   input wire logic i_speed_select_bit1,
   // configuration
   input wire scss_pkg::scss_mode_e i_mode,
   input wire logic i_auto_tune,
   // analog reference sample, full scale is +/-10 V
   input wire logic signed [`SCSS_ADC_W-1:0] i_analog_ref,
   input wire logic [`SCSS_SCALE_W-1:0] i_analog_speed_scale,
   // preset writes
   input wire logic [1:0] i_preset_wr,
   input wire logic i_preset_we,
   input wire logic signed [`SCSS_CMD_W-1:0] i_preset_wdata,
   // command outputs
   output logic signed [`SCSS_CMD_W-1:0] o_speed_cmd,
   output logic signed [`SCSS_CMD_W-1:0] o_speed_limit,
   output logic o_limit_active,
   output scss_pkg::scss_sel_e o_sel,
   // tuning policy
   output logic o_auto_adjust_en,
   output logic o_inertia_est_en
);
   import scss_pkg::*;

   // *****************************************************************
   // helpers
   // *****************************************************************

   // clamp a signed value into the preset span
   function automatic scss_cmd_t clamp_preset(input logic signed [`SCSS_CMD_W-1:0] v);
      if (v > `SCSS_PRESET_MAX) begin
         return `SCSS_PRESET_MAX;
      end else if (v < `SCSS_PRESET_MIN) begin
         return `SCSS_PRESET_MIN;
      end
      return v;
   endfunction

   // *****************************************************************
   // select synchroniser
   // *****************************************************************
   logic [1:0] sync1_q, sync1_d;
   logic [1:0] sync2_q, sync2_d;

   // pins are asynchronous to the drive clock
   always_comb begin
      sync1_d = sync1_q;
      sync2_d = sync2_q;
      if (i_ce) begin
         sync1_d = {i_speed_select_bit1, i_speed_select_bit0};
         sync2_d = sync1_q;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         sync1_q <= 2'h0;
         sync2_q <= 2'h0;
      end else begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
      end
   end

   // *****************************************************************
   // preset registers
   // *****************************************************************
   scss_cmd_t preset_q [3];
   scss_cmd_t preset_d [3];

   // writes to a nonzero index go through whenever i_ce is high, running or not
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         preset_d[i] = preset_q[i];
      end
      if (i_ce && i_preset_we && i_preset_wr != 2'h0) begin
         preset_d[i_preset_wr - 2'h1] = clamp_preset(i_preset_wdata);
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         for (int i = 0; i < 3; i++) begin
            preset_q[i] <= `SCSS_CMD_RESET;
         end
      end else begin
         for (int i = 0; i < 3; i++) begin
            preset_q[i] <= preset_d[i];
         end
      end
   end

   // *****************************************************************
   // analog scaling
   // *****************************************************************
   logic signed [`SCSS_ADC_W+`SCSS_SCALE_W:0] analog_prod;
   scss_cmd_t analog_cmd;

   // scale is unsigned, so widen with a zero sign bit
   always_comb begin
      analog_prod = i_analog_ref * $signed({1'b0, i_analog_speed_scale});
      analog_cmd = clamp_preset(
         18'(analog_prod >>> `SCSS_SCALE_SHIFT));
   end

   // *****************************************************************
   // command selection
   // *****************************************************************
   scss_sel_e sel;
   logic zero_mode;
   logic torque_mode;
   scss_cmd_t cmd_d, cmd_q;
   scss_sel_e sel_d, sel_q;
   logic limit_d, limit_q;
   scss_cmd_t tgt_d, tgt_q;
   scss_cmd_t lim_d, lim_q;

   always_comb begin
      sel = scss_sel_e'(sync2_q);
      zero_mode = (i_mode == SCSS_MODE_SPEED_ZERO) || (i_mode == SCSS_MODE_TORQUE_ZERO);
      torque_mode = (i_mode == SCSS_MODE_TORQUE) || (i_mode == SCSS_MODE_TORQUE_ZERO);
      cmd_d = cmd_q;
      sel_d = sel_q;
      limit_d = limit_q;
      tgt_d = tgt_q;
      lim_d = lim_q;
      if (i_ce) begin
         sel_d = sel;
         // torque modes flag the command as a limit
         limit_d = torque_mode;
         case (sel)
            SCSS_SEL_BASE: cmd_d = zero_mode ? `SCSS_CMD_RESET : analog_cmd;
            SCSS_SEL_PRESET1: cmd_d = preset_q[0];
            SCSS_SEL_PRESET2: cmd_d = preset_q[1];
            SCSS_SEL_PRESET3: cmd_d = preset_q[2];
            default: cmd_d = `SCSS_CMD_RESET;
         endcase
         // split here so both data outputs leave straight from flops
         tgt_d = torque_mode ? `SCSS_CMD_RESET : cmd_d;
         lim_d = torque_mode ? cmd_d : `SCSS_CMD_RESET;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         cmd_q <= `SCSS_CMD_RESET;
         sel_q <= SCSS_SEL_BASE;
         limit_q <= 1'b0;
         tgt_q <= `SCSS_CMD_RESET;
         lim_q <= `SCSS_CMD_RESET;
      end else begin
         cmd_q <= cmd_d;
         sel_q <= sel_d;
         limit_q <= limit_d;
         tgt_q <= tgt_d;
         lim_q <= lim_d;
      end
   end

   // *****************************************************************
   // tuning policy
   // *****************************************************************
   logic auto_d, auto_q;

   // mode changes take effect on the next edge with i_ce high only
   always_comb begin
      auto_d = auto_q;
      if (i_ce) begin
         auto_d = i_auto_tune;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         auto_q <= 1'b0;
      end else begin
         auto_q <= auto_d;
      end
   end

   assign o_auto_adjust_en = auto_q;
   assign o_inertia_est_en = auto_q;

   // outputs; the target and the limit are never both nonzero
   assign o_speed_cmd = tgt_q;
   assign o_speed_limit = lim_q;
   assign o_limit_active = limit_q;
   assign o_sel = sel_q;

   // *****************************************************************
   // assertions
   // *****************************************************************
   sequence base_zero_s;
      i_ce && sync2_q == 2'h0 && zero_mode;
   endsequence

   zero_default_a: assert property (@(posedge i_clk) disable iff (i_srst)
      base_zero_s |=> cmd_q == `SCSS_CMD_RESET)
      else $error("zero mode command not zero");

   analog_path_a: assert property (@(posedge i_clk) disable iff (i_srst)
      i_ce && sync2_q == 2'h0 && !zero_mode |=> cmd_q == $past(analog_cmd))
      else $error("analog command not passed");

   preset_pick_a: assert property (@(posedge i_clk) disable iff (i_srst)
      i_ce && sync2_q != 2'h0 |=> cmd_q == $past(preset_q[sync2_q - 2'h1]))
      else $error("wrong preset picked");

   // a pin change needs three enabled edges: two flops, then the output register
   sequence sel_window_s;
      i_ce [*3];
   endsequence

   sel_latency_a: assert property (@(posedge i_clk) disable iff (i_srst)
      sel_window_s
      |=> sel_q == scss_sel_e'($past({i_speed_select_bit1, i_speed_select_bit0}, 3)))
      else $error("select not applied in three cycles");

   sync_stage_a: assert property (@(posedge i_clk) disable iff (i_srst)
      i_ce |=> sync1_q == $past({i_speed_select_bit1, i_speed_select_bit0}))
      else $error("select pin not taken as on equals one");

   preset_range_a: assert property (@(posedge i_clk) disable iff (i_srst)
      preset_q[0] <= `SCSS_PRESET_MAX && preset_q[0] >= `SCSS_PRESET_MIN
      && preset_q[1] <= `SCSS_PRESET_MAX && preset_q[1] >= `SCSS_PRESET_MIN
      && preset_q[2] <= `SCSS_PRESET_MAX && preset_q[2] >= `SCSS_PRESET_MIN)
      else $error("preset out of span");

   analog_span_a: assert property (@(posedge i_clk) disable iff (i_srst)
      analog_cmd <= `SCSS_PRESET_MAX && analog_cmd >= `SCSS_PRESET_MIN)
      else $error("scaled analog command out of span");

   preset_write_a: assert property (@(posedge i_clk) disable iff (i_srst)
      i_ce && i_preset_we && i_preset_wr == 2'h2
      |=> preset_q[1] == clamp_preset($past(i_preset_wdata)))
      else $error("preset two not written");

   preset_one_write_a: assert property (@(posedge i_clk) disable iff (i_srst)
      i_ce && i_preset_we && i_preset_wr == 2'h1
      |=> preset_q[0] == clamp_preset($past(i_preset_wdata)))
      else $error("preset one not written");

   preset_three_write_a: assert property (@(posedge i_clk) disable iff (i_srst)
      i_ce && i_preset_we && i_preset_wr == 2'h3
      |=> preset_q[2] == clamp_preset($past(i_preset_wdata)))
      else $error("preset three not written");

   // index zero and a low enable must both leave the presets alone
   write_ignore_a: assert property (@(posedge i_clk) disable iff (i_srst)
      !(i_ce && i_preset_we && i_preset_wr != 2'h0)
      |=> $stable(preset_q[0]) && $stable(preset_q[1]) && $stable(preset_q[2]))
      else $error("preset changed without a write");

   torque_limit_a: assert property (@(posedge i_clk) disable iff (i_srst)
      i_ce && torque_mode && sync2_q != 2'h0
      |=> o_speed_limit == $past(preset_q[sync2_q - 2'h1]) && o_speed_cmd == `SCSS_CMD_RESET
      && o_limit_active)
      else $error("torque limit not routed");

   speed_target_a: assert property (@(posedge i_clk) disable iff (i_srst)
      i_ce && !torque_mode
      |=> o_speed_limit == `SCSS_CMD_RESET && o_speed_cmd == cmd_q && !o_limit_active)
      else $error("speed mode drove the limit");

   manual_tune_a: assert property (@(posedge i_clk) disable iff (i_srst)
      i_ce && !i_auto_tune |=> !o_auto_adjust_en && !o_inertia_est_en)
      else $error("manual mode left adjustment on");

   auto_tune_a: assert property (@(posedge i_clk) disable iff (i_srst)
      i_ce && i_auto_tune |=> o_auto_adjust_en && o_inertia_est_en)
      else $error("auto mode not enabled");

   // a low enable must leave every visible output but o_inertia_est_en, which copies o_auto_adjust_en, where it was
   freeze_hold_a: assert property (@(posedge i_clk) disable iff (i_srst)
      !i_ce |=> $stable(o_speed_cmd) && $stable(o_speed_limit) && $stable(o_sel)
      && $stable(o_limit_active) && $stable(o_auto_adjust_en))
      else $error("outputs moved while enable low");

   reset_zero_a: assert property (@(posedge i_clk)
      i_srst |=> cmd_q == `SCSS_CMD_RESET && o_speed_cmd == `SCSS_CMD_RESET
      && o_speed_limit == `SCSS_CMD_RESET && !o_limit_active)
      else $error("command not zero after reset");

endmodule // scss_selector

// ---- scss_ctrl_model.sv ----
// model of the external controller that drives the two speed select pins
`timescale 1ns/10ps
module scss_ctrl_model (
   // clock and requested select code
   input wire logic i_clk,
   input wire logic [1:0] i_code,
   // select pins, high while the input is on
   output logic o_bit0,
   output logic o_bit1
);
   // on drives one
   // code taken at the edge, pins move 2 ns later, so no race with the bench
   always @(posedge i_clk) begin
      {o_bit1, o_bit0} <= #2 i_code;
   end
endmodule // scss_ctrl_model

// ---- scss_selector_tb.sv ----
// self-checking bench for the speed command source selector
`timescale 1ns/10ps
module scss_selector_tb;
   import scss_pkg::*;
   logic i_clk, i_srst, i_ce, i_auto_tune, i_preset_we, b0, b1, o_limit_active;
   logic o_auto_adjust_en, o_inertia_est_en;
   logic [1:0] code, i_preset_wr;
   scss_mode_e i_mode;
   logic signed [15:0] i_analog_ref;
   logic [15:0] i_analog_speed_scale;
   logic signed [17:0] i_preset_wdata, o_speed_cmd, o_speed_limit;
   scss_sel_e o_sel;
   int miscompares = 0, checked = 0, cycles = 0;
   scss_selector uut (.i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce),
      .i_speed_select_bit0(b0), .i_speed_select_bit1(b1), .i_mode(i_mode),
      .i_auto_tune(i_auto_tune), .i_analog_ref(i_analog_ref),
      .i_analog_speed_scale(i_analog_speed_scale), .i_preset_wr(i_preset_wr),
      .i_preset_we(i_preset_we), .i_preset_wdata(i_preset_wdata),
      .o_speed_cmd(o_speed_cmd), .o_speed_limit(o_speed_limit),
      .o_limit_active(o_limit_active), .o_sel(o_sel),
      .o_auto_adjust_en(o_auto_adjust_en), .o_inertia_est_en(o_inertia_est_en));
   scss_ctrl_model ctrl (.i_clk(i_clk), .i_code(code), .o_bit0(b0), .o_bit1(b1));
   // 25 ns clock
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   // hang guard, the whole run needs about 83 cycles
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 2000) begin
         miscompares++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("counts: %0d checked, %0d miscompares", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #2;
   endtask
   task automatic chk_cmd(input logic signed [17:0] got, exp, input string what);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: %s got %0d exp %0d", $time, what, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, exp, input string what);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: %s got %b", $time, what, got);
      end
   endtask
   task automatic chk_sel(input scss_sel_e got, exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: select code got %0d", $time, got);
      end
   endtask
   task automatic wr(input logic [1:0] idx, input logic signed [17:0] val);
      i_preset_wr = idx;
      i_preset_we = 1'b1;
      i_preset_wdata = val;
      tick(1);
      i_preset_we = 1'b0;
      i_preset_wr = 2'b00;
      tick(1);
   endtask
   // presets clamped, picked by each select pattern, rewritten while running
   task automatic t_presets();
      logic signed [17:0] exp [1:3];
      exp = '{18'sh0c350, -18'sh03039, -18'sh0c350};
      wr(2'h1, 18'sh0ea60);
      wr(2'h2, -18'sh03039);
      wr(2'h3, -18'sh11170);
      wr(2'h0, 18'sh00309);
      for (int i = 1; i <= 3; i++) begin
         code = i[1:0];
         tick(5);
         chk_sel(o_sel, scss_sel_e'(i[1:0]));
         chk_cmd(o_speed_cmd, exp[i], "preset");
      end
      wr(2'h3, 18'sh00064);
      tick(2);
      chk_cmd(o_speed_cmd, 18'sh00064, "rewrite");
      $display("presets done");
   endtask
   // base select: scaled analog, clamped analog, forced zero
   task automatic t_base();
      code = 2'b00;
      i_analog_ref = 16'sh03e8;
      tick(5);
      chk_cmd(o_speed_cmd, 18'sh003e8, "analog unity");
      i_analog_ref = 16'sh8000;
      i_analog_speed_scale = 16'hffff;
      tick(2);
      chk_cmd(o_speed_cmd, -18'sh0c350, "analog clamp");
      i_mode = SCSS_MODE_SPEED_ZERO;
      tick(2);
      chk_cmd(o_speed_cmd, 18'sh00000, "zero mode");
      $display("base done");
   endtask
   // torque modes turn the command into a limit
   task automatic t_torque();
      i_mode = SCSS_MODE_TORQUE;
      code = 2'b01;
      tick(5);
      chk_cmd(o_speed_limit, 18'sh0c350, "limit");
      chk_cmd(o_speed_cmd, 18'sh00000, "torque target");
      chk_bit(o_limit_active, 1'b1, "limit active");
      i_mode = SCSS_MODE_TORQUE_ZERO;
      code = 2'b00;
      tick(5);
      chk_cmd(o_speed_limit, 18'sh00000, "zero limit");
      $display("torque done");
   endtask
   // a low enable freezes the selection until it returns
   task automatic t_freeze();
      i_mode = SCSS_MODE_SPEED;
      code = 2'b01;
      tick(5);
      chk_cmd(o_speed_cmd, 18'sh0c350, "before freeze");
      i_ce = 1'b0;
      code = 2'b10;
      tick(5);
      chk_cmd(o_speed_cmd, 18'sh0c350, "frozen cmd");
      chk_sel(o_sel, SCSS_SEL_PRESET1);
      i_ce = 1'b1;
      tick(5);
      chk_cmd(o_speed_cmd, -18'sh03039, "after freeze");
      chk_sel(o_sel, SCSS_SEL_PRESET2);
      $display("freeze done");
   endtask
   // mid-run reset clears the command, the limit flag and the presets
   task automatic t_reset();
      i_mode = SCSS_MODE_TORQUE;
      code = 2'b11;
      tick(5);
      chk_cmd(o_speed_limit, 18'sh00064, "limit before reset");
      i_srst = 1'b1;
      tick(2);
      chk_cmd(o_speed_limit, 18'sh00000, "limit in reset");
      chk_bit(o_limit_active, 1'b0, "flag in reset");
      chk_sel(o_sel, SCSS_SEL_BASE);
      i_srst = 1'b0;
      tick(5);
      chk_sel(o_sel, SCSS_SEL_PRESET3);
      chk_bit(o_limit_active, 1'b1, "flag after reset");
      chk_cmd(o_speed_limit, 18'sh00000, "cleared preset");
      $display("reset done");
   endtask
   // tuning policy follows the mode bit
   task automatic t_tune();
      i_auto_tune = 1'b1;
      tick(2);
      chk_bit(o_inertia_est_en, 1'b1, "estimation");
      chk_bit(o_auto_adjust_en, 1'b1, "auto adjust");
      i_auto_tune = 1'b0;
      tick(2);
      chk_bit(o_auto_adjust_en, 1'b0, "manual");
      chk_bit(o_inertia_est_en, 1'b0, "manual estimation");
      $display("tuning done");
   endtask
   // main sequence
   initial begin
      {i_srst, i_ce, i_auto_tune, i_preset_we} = 4'b1100;
      {code, i_preset_wr} = 4'h0;
      i_mode = SCSS_MODE_SPEED;
      i_analog_ref = 16'sd0;
      i_analog_speed_scale = 16'h8000;
      i_preset_wdata = 18'sd0;
      tick(6);
      chk_cmd(o_speed_cmd, 18'sh00000, "reset cmd");
      chk_sel(o_sel, SCSS_SEL_BASE);
      i_srst = 1'b0;
      t_presets();
      t_base();
      t_torque();
      t_freeze();
      t_reset();
      t_tune();
      complete_run();
   end
endmodule // scss_selector_tb
